// >>> src/sci_top.sv
// Sci speed command input: source select, mapping, buck faults
// Assumes analog and pwm pins arrive asynchronous; serial word synchronous
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module sci_top
  import sci_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Configuration
  input  wire logic [1:0]  src_sel,
  input  wire logic        device_power_variant,
  input  wire logic [1:0]  pwm_range_sel,
  input  wire logic [15:0] max_speed,
  input  wire logic [11:0] thr_enter,
  input  wire logic [11:0] thr_exit,
  input  wire logic [11:0] ana_full,
  input  wire logic [19:0] freq_full_period,
  input  wire logic [1:0]  slew_sel,
  // Speed inputs
  input  wire logic [11:0] ana_code,
  input  wire logic        speed_pin,
  input  wire logic [11:0] serial_speed,
  // Buck sense
  input  wire logic        buck_feedback_pin,
  input  wire logic        buck_ocp_pin,
  // Bridge
  input  wire logic        hs_req,
  input  wire logic        ls_req,
  input  wire logic        hs_off,
  input  wire logic        ls_off,
  // Outputs
  output logic [11:0]      duty_cmd,
  output logic [15:0]      speed_ref,
  output logic             src_valid,
  output logic             buck_off,
  output logic             dev_reset_req,
  output logic             hs_on,
  output logic             ls_on,
  output logic [3:0]       gate_drive
);

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [11:0] ana_s1;
  logic [11:0] ana_s2;
  logic [2:0]  pin_s;
  logic [1:0]  uv_s;
  logic [1:0]  ocp_s;
  // Two-stage sync; pin_s[2] is edge history only
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ana_s1 <= SCI_ZERO;
      ana_s2 <= SCI_ZERO;
      pin_s  <= 3'h0;
      uv_s   <= 2'h3;
      ocp_s  <= 2'h0;
    end else begin
      ana_s1 <= ana_code;
      ana_s2 <= ana_s1;
      pin_s  <= {pin_s[1:0], speed_pin};
      uv_s   <= {uv_s[0], buck_feedback_pin};
      ocp_s  <= {ocp_s[0], buck_ocp_pin};
    end
  end
  logic pin_lvl;
  logic pin_rise;
  assign pin_lvl  = pin_s[1];
  assign pin_rise = pin_s[1] && !pin_s[2];
  //////////////////////////////////////////////////////////////////////////
  // PWM duty and frequency measurement
  logic [19:0] per_cnt_r;
  logic [19:0] hi_cnt_r;
  logic [19:0] per_r;
  logic [19:0] hi_r;
  logic [19:0] per_lim;
  // Period ceiling per range selection
  always_comb begin
    unique case (pwm_range_sel)
      2'h0:    per_lim = 20'h003E8;
      2'h1:    per_lim = 20'h02710;
      2'h2:    per_lim = 20'h186A0;
      default: per_lim = 20'hFFFFF;
    endcase
  end
  // Count high time and period between rising edges
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt_r <= 20'h00000;
      hi_cnt_r  <= 20'h00000;
      per_r     <= 20'h00000;
      hi_r      <= 20'h00000;
    end else if (pin_rise) begin
      per_r     <= per_cnt_r;
      hi_r      <= hi_cnt_r;
      per_cnt_r <= 20'h00001;
      hi_cnt_r  <= 20'h00001;
    end else if (per_cnt_r >= per_lim) begin
      // Out of range: static pin gives 0 or 100 percent
      per_r     <= per_lim;
      hi_r      <= pin_lvl ? per_lim : 20'h00000;
      per_cnt_r <= 20'h00000;
      hi_cnt_r  <= 20'h00000;
    end else begin
      per_cnt_r <= per_cnt_r + 20'h00001;
      hi_cnt_r  <= hi_cnt_r + {19'h00000, pin_lvl};
    end
  end
  // Scale ratio to 12-bit fraction
  function automatic logic [11:0] sci_ratio(input logic [19:0] num,
                                             input logic [19:0] den);
    logic [31:0] q;
    q = 32'h0;
    if (den != 20'h0) begin
      q = ({num, 12'h000} - {12'h000, num}) / {12'h000, den};
    end
    sci_ratio = (q > 32'h00000FFF) ? SCI_FULL : q[11:0];
  endfunction
  logic [11:0] pwm_duty;
  logic [11:0] freq_lvl;
  assign pwm_duty = sci_ratio(hi_r, per_r);
  // Frequency as full period over measured period
  assign freq_lvl = (per_r == 20'h0) ? SCI_ZERO : sci_ratio(freq_full_period, per_r);
  //////////////////////////////////////////////////////////////////////////
  // Source selection and linear mapping
  logic [11:0] raw;
  logic [11:0] span_top;
  logic        pin_src;
  // Exactly four sources
  always_comb begin
    unique case (src_sel)
      SCI_SRC_ANALOG: begin raw = ana_s2;       span_top = ana_full; end
      SCI_SRC_PWM:    begin raw = pwm_duty;     span_top = SCI_FULL; end
      SCI_SRC_SERIAL: begin raw = serial_speed; span_top = SCI_FULL; end
      default:        begin raw = freq_lvl;     span_top = SCI_FULL; end
    endcase
  end
  assign pin_src = (src_sel != SCI_SRC_SERIAL);
  // Linear map from entry threshold to top, clamped at full
  function automatic logic [11:0] sci_map(input logic [11:0] v,
                                           input logic [11:0] lo,
                                           input logic [11:0] hi);
    logic [23:0] n;
    n = 24'h0;
    if (v >= hi || hi <= lo) begin
      sci_map = SCI_FULL;
    end else if (v <= lo) begin
      sci_map = SCI_ZERO;
    end else begin
      n = ({12'h000, v - lo} * {12'h000, SCI_FULL}) / {12'h000, hi - lo};
      sci_map = n[11:0];
    end
  endfunction
  logic        run_r;
  logic [11:0] duty_r;
  logic        valid_r;
  logic        allowed;
  // Pin sources need the standby variant; serial word always
  assign allowed = !pin_src || (device_power_variant == SCI_VARIANT_STANDBY);
  // Run state with hysteresis band
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      run_r <= 1'b0;
    end else if (!allowed || raw <= thr_enter) begin
      run_r <= 1'b0;
    end else if (raw >= thr_exit) begin
      run_r <= 1'b1;
    end
  end // between thresholds: hold
  // Duty command
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      duty_r  <= SCI_ZERO;
      valid_r <= 1'b0;
    end else begin
      valid_r <= allowed;
      if (!run_r) begin
        duty_r <= SCI_ZERO;
      end else if (raw > span_top) begin
        duty_r <= SCI_FULL;
      end else begin
        duty_r <= sci_map(raw, thr_enter, span_top);
      end
    end
  end
  // Speed reference scaled by top speed
  logic [15:0] ref_r;
  logic [27:0] ref_prod;
  assign ref_prod = {12'h000, max_speed} * {16'h0000, duty_r};
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ref_r <= SCI_MAX_ZERO;
    end else if (max_speed == SCI_MAX_ZERO) begin
      ref_r <= SCI_MAX_ZERO;
    end else begin
      ref_r <= ref_prod[27:12];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Buck protection
  logic [7:0] ocp_cnt_r;
  logic       buck_off_r;
  logic       rst_req_r;
  // Overcurrent must persist past the deglitch count
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ocp_cnt_r <= 8'h00;
    end else if (!ocp_s[1]) begin
      ocp_cnt_r <= 8'h00;
    end else if (ocp_cnt_r <= 8'(SCI_OCP_DEG_CYC)) begin
      ocp_cnt_r <= ocp_cnt_r + 8'h01;
    end
  end
  // Sticky off until device reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      buck_off_r <= 1'b0;
      rst_req_r  <= 1'b0;
    end else if (!uv_s[1] || ocp_cnt_r > 8'(SCI_OCP_DEG_CYC)) begin
      buck_off_r <= 1'b1;
      rst_req_r  <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bridge and outputs
  sci_bridge_il u_bridge (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .hs_req     (hs_req),
    .ls_req     (ls_req),
    .drv_en     (!buck_off_r),
    .slew_sel   (slew_sel),
    .hs_off     (hs_off),
    .ls_off     (ls_off),
    .hs_on      (hs_on),
    .ls_on      (ls_on),
    .gate_drive (gate_drive)
  );
  assign duty_cmd      = duty_r;
  assign speed_ref     = ref_r;
  assign src_valid     = valid_r;
  assign buck_off      = buck_off_r;
  assign dev_reset_req = rst_req_r;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_ref_top_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(max_speed) == SCI_MAX_ZERO |-> ref_r == SCI_MAX_ZERO)
    else $error("speed ref not zero at zero top speed");
  a_duty_stop: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !run_r |=> duty_r == SCI_ZERO) else $error("duty not zero when stopped");
  a_duty_clamp: assert property (@(posedge clk_sys) disable iff (sys_rst)
    run_r && raw > span_top |=> duty_r == SCI_FULL)
    else $error("duty not clamped");
  a_variant_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pin_src && device_power_variant == SCI_VARIANT_SLEEP |=> !run_r)
    else $error("pin source ran in sleep variant");
  a_run_hyst: assert property (@(posedge clk_sys) disable iff (sys_rst)
    allowed && raw > thr_enter && raw < thr_exit |=> run_r == $past(run_r))
    else $error("hysteresis state changed");
  a_buck_uv_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !uv_s[1] |=> buck_off_r && rst_req_r) else $error("uv not acted on");
  a_ocp_deglitch: assert property (@(posedge clk_sys) disable iff (sys_rst)
    uv_s[1] && !buck_off_r && ocp_cnt_r <= 8'(SCI_OCP_DEG_CYC) |=> !buck_off_r)
    else $error("ocp without deglitch");
  a_buck_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    buck_off_r |=> !hs_on && !ls_on) else $error("bridge on after buck off");
  c_run_analog: cover property (@(posedge clk_sys) src_sel == SCI_SRC_ANALOG && run_r);
  c_run_pwm:    cover property (@(posedge clk_sys) src_sel == SCI_SRC_PWM && run_r);
  c_run_serial: cover property (@(posedge clk_sys) src_sel == SCI_SRC_SERIAL && run_r);
  c_run_freq:   cover property (@(posedge clk_sys) src_sel == SCI_SRC_FREQ && run_r);
  c_buck_trip:  cover property (@(posedge clk_sys) $rose(buck_off_r));
endmodule

// >>> src/sci_pkg.sv
// Speed command input: shared constants and types
// Assumes a 25 MHz system clock; all sizes fixed
package sci_pkg;

  // Speed source select codes
  typedef enum logic [1:0] {
    SCI_SRC_ANALOG = 2'h0,
    SCI_SRC_PWM    = 2'h1,
    SCI_SRC_SERIAL = 2'h2,
    SCI_SRC_FREQ   = 2'h3
  } sci_src_t;

  // Power variant codes
  localparam logic SCI_VARIANT_STANDBY = 1'h0;
  localparam logic SCI_VARIANT_SLEEP   = 1'h1;

  // Data widths and full scale
  localparam int          SCI_W        = 12;
  localparam logic [11:0] SCI_FULL     = 12'hFFF;
  localparam logic [11:0] SCI_ZERO     = 12'h000;
  localparam logic [15:0] SCI_MAX_ZERO = 16'h0000;

  // PWM measurement counter width and fastest range select code
  localparam int          SCI_CNT_W    = 20;
  localparam logic [1:0]  SCI_RNG_HIGH = 2'h0;

  // Clock and time
  localparam int SCI_CLK_HZ       = 25_000_000;
  localparam int SCI_OCP_DEG_NS   = 5000;
  localparam int SCI_OCP_DEG_CYC  =
    (SCI_OCP_DEG_NS * (SCI_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SCI_DEAD_MIN_NS  = 40;
  localparam int SCI_DEAD_CYC     =
    (SCI_DEAD_MIN_NS * (SCI_CLK_HZ / 1_000_000) + 999) / 1000;

  // Slew settings: 25, 50, 125, 200 V/us
  typedef enum logic [1:0] {
    SCI_SLEW_25  = 2'h0,
    SCI_SLEW_50  = 2'h1,
    SCI_SLEW_125 = 2'h2,
    SCI_SLEW_200 = 2'h3
  } sci_slew_t;

  // Gate current code per slew setting
  function automatic logic [3:0] sci_slew_drive(input logic [1:0] s);
    unique case (s)
      2'h0:    sci_slew_drive = 4'h1;
      2'h1:    sci_slew_drive = 4'h2;
      2'h2:    sci_slew_drive = 4'h5;
      default: sci_slew_drive = 4'h8;
    endcase
  endfunction

endpackage

// >>> src/sci_bridge_il.sv
// Sci half-bridge interlock with slew drive select
// Assumes gate-off sense inputs already synchronous to clk_sys
`timescale 1ns/1ps
module sci_bridge_il
  import sci_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Requests and enables
  input  wire logic       hs_req,
  input  wire logic       ls_req,
  input  wire logic       drv_en,
  input  wire logic [1:0] slew_sel,
  // Gate-off sense
  input  wire logic       hs_off,
  input  wire logic       ls_off,
  // Gate outputs
  output logic            hs_on,
  output logic            ls_on,
  output logic [3:0]      gate_drive
);

  logic hs_on_r;
  logic ls_on_r;
  logic [3:0] gate_drive_r;

  assign hs_on      = hs_on_r;
  assign ls_on      = ls_on_r;
  assign gate_drive = gate_drive_r;

  // Turn on only once the opposite gate is sensed off
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hs_on_r <= 1'b0;
      ls_on_r <= 1'b0;
    end else begin
      hs_on_r <= drv_en && hs_req && !ls_req && ls_off && !ls_on_r;
      ls_on_r <= drv_en && ls_req && !hs_req && hs_off && !hs_on_r;
    end
  end

  // Slew setting to gate current
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gate_drive_r <= 4'h1;
    end else begin
      gate_drive_r <= sci_slew_drive(slew_sel);
    end
  end

  a_il_no_shoot: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(hs_on_r && ls_on_r)) else $error("both switches on");
  a_il_hs_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(hs_on_r) |-> $past(ls_off) && !$past(ls_on_r))
    else $error("high side on before low side off");

endmodule

// >>> test/sci_pin_src.sv
// Speed pin source model: square wave of set period and high time
// Assumes counts held steady while run is high
`timescale 1ns/1ps
module sci_pin_src (
  // Clock and control
  input  wire logic        clk_sys,
  input  wire logic        run,
  input  wire logic [19:0] period,
  input  wire logic [19:0] high_cnt,
  // Pin
  output logic             speed_pin
);
  logic [19:0] cnt_r;

  // Period counter, parked at zero when stopped
  always_ff @(posedge clk_sys) begin
    if (!run || cnt_r >= period - 20'h1) cnt_r <= 20'h0;
    else cnt_r <= cnt_r + 20'h1;
  end

  // Pin level; idles low outside bursts
  always_ff @(posedge clk_sys) begin
    speed_pin <= run && (cnt_r < high_cnt);
  end
endmodule

// >>> test/speed_command_input_tb.sv
// Speed command input testbench: directed scenarios per source and fault
// Assumes sci_top and the pin source model on a 25 MHz clock
`timescale 1ns/1ps
module speed_command_input_tb;
  import sci_pkg::*;
  logic        clk_sys, sys_rst, device_power_variant, speed_pin, pin_run;
  logic        buck_feedback_pin, buck_ocp_pin, hs_req, ls_req, hs_off, ls_off;
  logic        src_valid, buck_off, dev_reset_req, hs_on, ls_on;
  logic [1:0]  src_sel, pwm_range_sel, slew_sel;
  logic [11:0] thr_enter, thr_exit, ana_full, ana_code, serial_speed, duty_cmd;
  logic [15:0] max_speed, speed_ref;
  logic [19:0] freq_full_period, pin_per, pin_hi;
  logic [3:0]  gate_drive;
  int          err_count, total_checks;

  sci_top u_dut (
    .clk_sys, .sys_rst, .src_sel, .device_power_variant, .pwm_range_sel,
    .max_speed, .thr_enter, .thr_exit, .ana_full, .freq_full_period, .slew_sel,
    .ana_code, .speed_pin, .serial_speed, .buck_feedback_pin, .buck_ocp_pin,
    .hs_req, .ls_req, .hs_off, .ls_off, .duty_cmd, .speed_ref, .src_valid,
    .buck_off, .dev_reset_req, .hs_on, .ls_on, .gate_drive
  );
  sci_pin_src u_src (.clk_sys, .run(pin_run), .period(pin_per), .high_cnt(pin_hi),
    .speed_pin);

  //////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Wait n edges, then settle
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Verdict and stop
  task automatic end_of_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Reset pulse with fault pins quiet
  task automatic do_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    buck_feedback_pin <= 1'b1;
    buck_ocp_pin <= 1'b0;
    wt(5);
    chk("rst_off", 16'h0, 16'(buck_off));
    @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask

  // Drive analog code and let it pass the syncs
  task automatic set_ana(input logic [11:0] v);
    @(posedge clk_sys);
    ana_code <= v;
    wt(8);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Serial word, both variants, top speed zero
  task automatic t_serial();
    @(posedge clk_sys);
    src_sel <= SCI_SRC_SERIAL;
    serial_speed <= SCI_FULL;
    wt(4);
    chk("ser_duty", 16'hFFF, 16'(duty_cmd));
    chk("ser_ref", 16'h0FFF, speed_ref);
    @(posedge clk_sys);
    device_power_variant <= SCI_VARIANT_SLEEP;
    max_speed <= 16'h0000;
    wt(4);
    chk("ser_valid", 16'h1, 16'(src_valid));
    chk("ser_sleep", 16'hFFF, 16'(duty_cmd));
    chk("ref_zero", 16'h0, speed_ref);
    @(posedge clk_sys);
    device_power_variant <= SCI_VARIANT_STANDBY;
    max_speed <= 16'h1000;
  endtask

  // Analog zero region, clamp, hysteresis, sleep refusal
  task automatic t_analog();
    @(posedge clk_sys);
    src_sel <= SCI_SRC_ANALOG;
    set_ana(12'h000);
    chk("ana_zero", 16'h0, 16'(duty_cmd));
    set_ana(12'hFFF);
    chk("ana_clamp", 16'hFFF, 16'(duty_cmd));
    set_ana(12'h180);
    chk("ana_hold_run", 16'h1, 16'(duty_cmd != 12'h000));
    set_ana(12'h050);
    chk("ana_enter", 16'h0, 16'(duty_cmd));
    set_ana(12'h180);
    chk("ana_hold_stop", 16'h0, 16'(duty_cmd));
    @(posedge clk_sys);
    device_power_variant <= SCI_VARIANT_SLEEP;
    set_ana(12'hFFF);
    chk("ana_sleep", 16'h0, 16'(duty_cmd));
    chk("ana_valid", 16'h0, 16'(src_valid));
    @(posedge clk_sys);
    device_power_variant <= SCI_VARIANT_STANDBY;
  endtask

  // PWM duty in a slow and a fast range, then pin stopped
  task automatic t_pwm();
    @(posedge clk_sys);
    src_sel <= SCI_SRC_PWM;
    pwm_range_sel <= 2'h1;
    pin_per <= 20'd1500;
    pin_hi <= 20'd750;
    pin_run <= 1'b1;
    wt(2000);
    chk("pwm_slow", 16'h1, 16'(duty_cmd > 12'h000 && duty_cmd < SCI_FULL));
    @(posedge clk_sys);
    pwm_range_sel <= SCI_RNG_HIGH;
    pin_per <= 20'd100;
    pin_hi <= 20'd50;
    wt(600);
    chk("pwm_mid", 16'h1, 16'(duty_cmd > 12'h000 && duty_cmd < SCI_FULL));
    @(posedge clk_sys);
    pin_run <= 1'b0;
    wt(2500);
    chk("pwm_stop", 16'h0, 16'(duty_cmd));
  endtask

  // Frequency source: above full frequency clamps
  task automatic t_freq();
    @(posedge clk_sys);
    src_sel <= SCI_SRC_FREQ;
    freq_full_period <= 20'd200;
    pin_per <= 20'd100;
    pin_run <= 1'b1;
    wt(800);
    chk("freq_clamp", 16'hFFF, 16'(duty_cmd));
    @(posedge clk_sys);
    pin_run <= 1'b0;
  endtask

  // Slew codes and gate interlock both ways
  task automatic t_bridge();
    logic [3:0] gd [4] = '{4'h1, 4'h2, 4'h5, 4'h8};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      slew_sel <= 2'(i);
      wt(3);
      chk("slew", 16'(gd[i]), 16'(gate_drive));
    end
    @(posedge clk_sys);
    ls_off <= 1'b0;
    hs_req <= 1'b1;
    wt(10);
    chk("hs_block", 16'h0, 16'(hs_on));
    @(posedge clk_sys);
    ls_off <= 1'b1;
    wt(4);
    chk("hs_go", 16'h1, 16'(hs_on));
    @(posedge clk_sys);
    hs_req <= 1'b0;
    hs_off <= 1'b0;
    ls_req <= 1'b1;
    wt(10);
    chk("ls_block", 16'h0, 16'(ls_on));
    @(posedge clk_sys);
    hs_off <= 1'b1;
    wt(4);
    chk("ls_go", 16'h1, 16'(ls_on));
    @(posedge clk_sys);
    ls_req <= 1'b0;
  endtask

  // Buck overcurrent deglitch, then undervoltage
  task automatic t_buck();
    @(posedge clk_sys);
    buck_ocp_pin <= 1'b1;
    wt(60);
    @(posedge clk_sys);
    buck_ocp_pin <= 1'b0;
    wt(3);
    chk("ocp_glitch", 16'h0, 16'(buck_off));
    @(posedge clk_sys);
    buck_ocp_pin <= 1'b1;
    wt(200);
    chk("ocp_trip", 16'h1, 16'(buck_off));
    chk("ocp_reset", 16'h1, 16'(dev_reset_req));
    do_reset();
    @(posedge clk_sys);
    buck_feedback_pin <= 1'b0;
    wt(5);
    chk("uv_trip", 16'h1, 16'(dev_reset_req));
    @(posedge clk_sys);
    buck_feedback_pin <= 1'b1;
    wt(5);
    chk("uv_sticky", 16'h1, 16'(buck_off));
    do_reset();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_count = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    {device_power_variant, pin_run, hs_req, ls_req} = 4'h0;
    {buck_feedback_pin, buck_ocp_pin, hs_off, ls_off} = 4'hB;
    {src_sel, pwm_range_sel, slew_sel} = 6'h00;
    thr_enter = 12'h100;
    thr_exit = 12'h200;
    ana_full = 12'hC00;
    ana_code = 12'h000;
    serial_speed = 12'h000;
    max_speed = 16'h1000;
    freq_full_period = 20'd200;
    pin_per = 20'd100;
    pin_hi = 20'd50;
    do_reset();
    // Pause before the first command; startup wait scaled down
    wt(4);
    t_serial();
    t_analog();
    t_pwm();
    t_freq();
    t_bridge();
    t_buck();
    end_of_test();
  end

  // Watchdog on a generous cycle budget
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    end_of_test();
  end
endmodule
